// >>> hdl/cmd_check_pkg.sv
// Constants for the command parameter checker
package cmd_check_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD_INFO = 8'h00;
  localparam logic [7:0] REG_SG_ELEM = 8'h04;
  localparam logic [7:0] REG_LENGTHS = 8'h08;
  localparam logic [7:0] REG_CONFIG = 8'h0C;
  localparam logic [7:0] REG_EVENT = 8'h10;
  localparam logic [7:0] REG_CONTROL = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_WQ0_TMO = 8'h1C;
  localparam logic [7:0] REG_BUS_TMO = 8'h20;
  localparam logic [7:0] REG_SEL_TMO = 8'h24;
  localparam logic [7:0] REG_TMO_CYC = 8'h28;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  // Command info word
  localparam int CI_TYPE_LSB = 0;        // 8 bit type
  localparam int CI_SGCNT_LSB = 8;       // 8 bit element count
  localparam int CI_SG_BIT = 16;
  localparam int CI_PRINTER_BIT = 17;
  localparam int CI_BUFFER_BIT = 18;
  localparam int CI_RSVD_BIT = 19;       // reserved fields nonzero
  localparam int CI_DIR_BIT = 20;        // 1 = data in
  // Scatter/gather element word
  localparam int SG_COUNT_LSB = 0;       // 16 bit byte count
  localparam int SG_MEMTYPE_LSB = 16;    // 4 bit memory type
  localparam int SG_ADDR_OK_BIT = 20;
  // Config word
  localparam int CF_OFFBOARD_BIT = 0;
  localparam int CF_PRN_READY_BIT = 1;
  localparam int CF_ABORT_EN_BIT = 2;
  localparam int CF_BUFSIZE_LSB = 16;    // 16 bit permitted buffer size
  // Event word
  localparam int EV_RESEL_BIT = 0;
  localparam int EV_PENDING_BIT = 1;
  localparam int EV_XFER_ZERO_BIT = 2;
  localparam int EV_DATA_REQ_BIT = 3;
  localparam int EV_PHASE_IN_BIT = 4;
  localparam int EV_PRN_CHANGE_BIT = 5;
  localparam int EV_FAULT_BIT = 6;
  // Control word (write one pulses)
  localparam int CT_CHECK_BIT = 0;
  localparam int CT_FLUSH_BIT = 1;
  localparam int CT_ABORT_ACK_BIT = 2;
  localparam int CT_START_BIT = 3;
  localparam int CT_DONE_BIT = 4;
  // ---------------------------------------------------------------
  // Status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_RESERVED = 8'h10;
  localparam logic [7:0] ST_SG_COUNT = 8'h2E;
  localparam logic [7:0] ST_SG_ODD = 8'h40;
  localparam logic [7:0] ST_SG_MEMTYPE = 8'h41;
  localparam logic [7:0] ST_SG_ADDR = 8'h42;
  localparam logic [7:0] ST_BUF_COUNT = 8'h50;
  localparam logic [7:0] ST_BUF_OFFBOARD = 8'h51;
  localparam logic [7:0] ST_FLUSH_ERR = 8'h80;
  localparam logic [7:0] ST_FLUSH_CMD = 8'h81;
  localparam logic [7:0] ST_MISSING = 8'h82;
  localparam logic [7:0] ST_EXHAUSTED = 8'h83;
  localparam logic [7:0] ST_DIRECTION = 8'h84;
  localparam logic [7:0] ST_PRN_CHANGE = 8'h90;
  localparam logic [7:0] ST_PRN_SHORT = 8'h91;
  localparam logic [7:0] ST_PRN_ZERO = 8'h92;
  localparam logic [7:0] ST_PRN_ABSENT = 8'h93;
  localparam logic [7:0] ST_PRN_SG = 8'h99;
  localparam logic [7:0] ST_BAD_TYPE = 8'hC0;
  localparam logic [7:0] ST_TIMEOUT = 8'hC1;
  // ---------------------------------------------------------------
  // Types, limits, timing
  // ---------------------------------------------------------------
  localparam logic [7:0] TYPE_MAX = 8'h03;      // supported types 0..3
  localparam logic [7:0] SG_MIN = 8'h01;
  localparam logic [7:0] SG_MAX = 8'h40;
  localparam logic [3:0] MEMTYPE_MAX = 4'h3;
  localparam int CLK_MHZ = 250;
  localparam int WQ0_TICK_MS = 256;
  localparam int BUS_DEFAULT_MS = 100;
  localparam int SEL_TICK_MS = 1;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam logic [31:0] WQ0_TICK_CYC = 32'(WQ0_TICK_MS * CYC_PER_MS);
  localparam logic [31:0] BUS_DEFAULT_CYC = 32'(BUS_DEFAULT_MS * CYC_PER_MS);
  localparam logic [31:0] SEL_TICK_CYC = 32'(SEL_TICK_MS * CYC_PER_MS);
endpackage

// >>> hdl/cmd_check.sv
// Command parameter checker and completion status reporter
`timescale 1ns/10ps
module cmd_check (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic status_valid,
  output logic [7:0] status_code,
  output logic bus_timeout,
  output logic sel_timeout
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, RUNNING, FLUSHING} mode_e;

  typedef struct packed {
    logic [31:0] cmd_info;
    logic [31:0] sg_elem;
    logic [31:0] lengths;
    logic [31:0] config_w;
    logic [31:0] event_w;
    logic [31:0] wq0_tmo;
    logic [31:0] bus_tmo;
    logic [31:0] sel_tmo;
    logic [31:0] wq0_cnt;
    logic [31:0] bus_cnt;
    logic [31:0] sel_cnt;
    logic [31:0] tick_cnt;
    logic [31:0] wq0_ticks;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic status_valid;
    logic [7:0] status_code;
    logic bus_timeout;
    logic sel_timeout;
    logic prn_prev;
    mode_e mode;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Tick lengths in cycles; a full tick is far longer than any short run
  logic [31:0] wq0_tick_cyc;
  logic [31:0] bus_default_cyc;
  logic [31:0] sel_tick_cyc;
  assign wq0_tick_cyc = cmd_check_pkg::WQ0_TICK_CYC;
  assign bus_default_cyc = cmd_check_pkg::BUS_DEFAULT_CYC;
  assign sel_tick_cyc = cmd_check_pkg::SEL_TICK_CYC;

  // ---------------------------------------------------------------
  // Command validation, first failing check wins
  // ---------------------------------------------------------------
  function automatic logic [7:0] check_cmd(input logic [31:0] ci, input logic [31:0] sg,
                                           input logic [31:0] ln, input logic [31:0] cf);
    logic [7:0] ctype;
    logic [7:0] sgcnt;
    logic [15:0] maxlen;
    logic [15:0] prnlen;
    logic [7:0] res;
    ctype = ci[cmd_check_pkg::CI_TYPE_LSB +: 8];
    sgcnt = ci[cmd_check_pkg::CI_SGCNT_LSB +: 8];
    maxlen = ln[15:0];
    prnlen = ln[31:16];
    res = cmd_check_pkg::ST_OK;
    // Order of the chain fixes which single code is reported
    if (ci[cmd_check_pkg::CI_RSVD_BIT]) begin
      res = cmd_check_pkg::ST_RESERVED;
    end else if (ctype > cmd_check_pkg::TYPE_MAX) begin
      res = cmd_check_pkg::ST_BAD_TYPE;
    end else if (ci[cmd_check_pkg::CI_PRINTER_BIT]) begin
      if (ci[cmd_check_pkg::CI_SG_BIT]) begin
        res = cmd_check_pkg::ST_PRN_SG;
      end else if (!cf[cmd_check_pkg::CF_PRN_READY_BIT]) begin
        res = cmd_check_pkg::ST_PRN_ABSENT;
      end else if (maxlen == 16'h0000 && prnlen != 16'h0000) begin
        res = cmd_check_pkg::ST_PRN_ZERO;
      end else if (maxlen < prnlen) begin
        res = cmd_check_pkg::ST_PRN_SHORT;
      end
    end else if (ci[cmd_check_pkg::CI_BUFFER_BIT]) begin
      if (cf[cmd_check_pkg::CF_OFFBOARD_BIT]) begin
        res = cmd_check_pkg::ST_BUF_OFFBOARD;
      end else if (maxlen > cf[cmd_check_pkg::CF_BUFSIZE_LSB +: 16]) begin
        res = cmd_check_pkg::ST_BUF_COUNT;
      end
    end else if (ci[cmd_check_pkg::CI_SG_BIT]) begin
      if (sgcnt < cmd_check_pkg::SG_MIN || sgcnt > cmd_check_pkg::SG_MAX) begin
        res = cmd_check_pkg::ST_SG_COUNT;
      end else if (sg[cmd_check_pkg::SG_COUNT_LSB]) begin
        res = cmd_check_pkg::ST_SG_ODD;
      end else if (sg[cmd_check_pkg::SG_MEMTYPE_LSB +: 4] > cmd_check_pkg::MEMTYPE_MAX) begin
        res = cmd_check_pkg::ST_SG_MEMTYPE;
      end else if (!sg[cmd_check_pkg::SG_ADDR_OK_BIT]) begin
        res = cmd_check_pkg::ST_SG_ADDR;
      end
    end
    return res;
  endfunction

  // Timeout limit in cycles from a count of units
  function automatic logic [31:0] scale(input logic [31:0] units, input logic [31:0] per);
    return 32'(units * per);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic [31:0] ev;
    logic [31:0] ct;
    logic [7:0] code;
    logic post;
    logic bus_lim_hit;
    logic [31:0] bus_lim;
    st_nxt = st_r;
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    ev = st_r.event_w;
    ct = 32'h0000_0000;
    code = cmd_check_pkg::ST_OK;
    post = 1'b0;
    bus_lim = 32'h0000_0000;
    bus_lim_hit = 1'b0;
    st_nxt.pready = psel && !penable;
    st_nxt.pslverr = 1'b0;
    st_nxt.status_valid = 1'b0;
    st_nxt.bus_timeout = 1'b0;
    st_nxt.sel_timeout = 1'b0;
    // No wait state: ready stands through the first access cycle
    if (psel && penable && st_r.pready) begin
      st_nxt.pready = 1'b0;
      if (wr) begin
        unique case (paddr)
          cmd_check_pkg::REG_CMD_INFO: st_nxt.cmd_info = pwdata;
          cmd_check_pkg::REG_SG_ELEM: st_nxt.sg_elem = pwdata;
          cmd_check_pkg::REG_LENGTHS: st_nxt.lengths = pwdata;
          cmd_check_pkg::REG_CONFIG: st_nxt.config_w = pwdata;
          cmd_check_pkg::REG_EVENT: begin
            st_nxt.event_w = pwdata;
            ev = pwdata;
          end
          cmd_check_pkg::REG_CONTROL: ct = pwdata;
          cmd_check_pkg::REG_WQ0_TMO: st_nxt.wq0_tmo = pwdata;
          cmd_check_pkg::REG_BUS_TMO: st_nxt.bus_tmo = pwdata;
          cmd_check_pkg::REG_SEL_TMO: st_nxt.sel_tmo = pwdata;
          default: ;
        endcase
      end
    end
    if (rd) begin
      unique case (paddr)
        cmd_check_pkg::REG_CMD_INFO: st_nxt.prdata = st_r.cmd_info;
        cmd_check_pkg::REG_SG_ELEM: st_nxt.prdata = st_r.sg_elem;
        cmd_check_pkg::REG_LENGTHS: st_nxt.prdata = st_r.lengths;
        cmd_check_pkg::REG_CONFIG: st_nxt.prdata = st_r.config_w;
        cmd_check_pkg::REG_EVENT: st_nxt.prdata = st_r.event_w;
        cmd_check_pkg::REG_CONTROL: st_nxt.prdata = 32'h0000_0000;
        cmd_check_pkg::REG_STATUS: st_nxt.prdata = {22'h00_0000, st_r.mode, st_r.status_code};
        cmd_check_pkg::REG_WQ0_TMO: st_nxt.prdata = st_r.wq0_tmo;
        cmd_check_pkg::REG_BUS_TMO: st_nxt.prdata = st_r.bus_tmo;
        cmd_check_pkg::REG_SEL_TMO: st_nxt.prdata = st_r.sel_tmo;
        cmd_check_pkg::REG_TMO_CYC: st_nxt.prdata = st_r.wq0_ticks;
        default: st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // Error rides with ready, so it is decided in the setup cycle
    if (psel && !penable) begin
      st_nxt.pslverr = (paddr > cmd_check_pkg::REG_TMO_CYC) || (paddr[1:0] != 2'b00)
                       || (pwrite && (paddr == cmd_check_pkg::REG_STATUS
                                      || paddr == cmd_check_pkg::REG_TMO_CYC));
    end

    // Link events; running checks use the event word as written this cycle, printer change the stored word
    st_nxt.prn_prev = st_r.event_w[cmd_check_pkg::EV_PRN_CHANGE_BIT];
    if (st_r.event_w[cmd_check_pkg::EV_PRN_CHANGE_BIT] && !st_r.prn_prev) begin
      code = cmd_check_pkg::ST_PRN_CHANGE;
      post = 1'b1;
    end
    if (st_r.mode == RUNNING) begin
      if (ev[cmd_check_pkg::EV_RESEL_BIT] && !ev[cmd_check_pkg::EV_PENDING_BIT]) begin
        code = cmd_check_pkg::ST_MISSING;
        post = 1'b1;
      end else if (ev[cmd_check_pkg::EV_XFER_ZERO_BIT] && ev[cmd_check_pkg::EV_DATA_REQ_BIT]) begin
        code = cmd_check_pkg::ST_EXHAUSTED;
        post = 1'b1;
      end else if (ev[cmd_check_pkg::EV_DATA_REQ_BIT]
                   && ev[cmd_check_pkg::EV_PHASE_IN_BIT]
                      != st_r.cmd_info[cmd_check_pkg::CI_DIR_BIT]) begin
        code = cmd_check_pkg::ST_DIRECTION;
        post = 1'b1;
      end else if (ev[cmd_check_pkg::EV_FAULT_BIT]
                   && st_r.wq0_tmo != 32'h0000_0000
                   && st_r.wq0_ticks >= st_r.wq0_tmo) begin
        code = cmd_check_pkg::ST_TIMEOUT;
        post = 1'b1;
      end
      if (post && code != cmd_check_pkg::ST_PRN_CHANGE) begin
        st_nxt.mode = st_r.config_w[cmd_check_pkg::CF_ABORT_EN_BIT] ? FLUSHING : IDLE;
      end
    end

    // Control pulses
    if (ct[cmd_check_pkg::CT_CHECK_BIT]) begin
      if (st_r.mode == FLUSHING) begin
        code = cmd_check_pkg::ST_FLUSH_ERR;
      end else if (ct[cmd_check_pkg::CT_FLUSH_BIT]) begin
        code = cmd_check_pkg::ST_FLUSH_CMD;
      end else begin
        code = check_cmd(st_r.cmd_info, st_r.sg_elem, st_r.lengths, st_r.config_w);
        if (code != cmd_check_pkg::ST_OK && st_r.config_w[cmd_check_pkg::CF_ABORT_EN_BIT]) begin
          st_nxt.mode = FLUSHING;
        end
      end
      post = 1'b1;
    end
    if (ct[cmd_check_pkg::CT_ABORT_ACK_BIT] && st_r.mode == FLUSHING) begin
      st_nxt.mode = IDLE;
    end
    if (ct[cmd_check_pkg::CT_START_BIT] && st_r.mode == IDLE) begin
      st_nxt.mode = RUNNING;
    end
    if (ct[cmd_check_pkg::CT_DONE_BIT] && st_r.mode == RUNNING) begin
      st_nxt.mode = IDLE;
    end
    if (post) begin
      st_nxt.status_valid = 1'b1;
      st_nxt.status_code = code;
    end

    // ---------------------------------------------------------------
    // Timeout counters
    // ---------------------------------------------------------------
    if (st_r.mode != RUNNING || ct[cmd_check_pkg::CT_START_BIT]) begin
      st_nxt.tick_cnt = 32'h0000_0000;
      st_nxt.wq0_ticks = 32'h0000_0000;
      st_nxt.bus_cnt = 32'h0000_0000;
      st_nxt.sel_cnt = 32'h0000_0000;
    end else begin
      if (st_r.tick_cnt >= wq0_tick_cyc - 32'h0000_0001) begin
        st_nxt.tick_cnt = 32'h0000_0000;
        st_nxt.wq0_ticks = st_r.wq0_ticks + 32'h0000_0001;
      end else begin
        st_nxt.tick_cnt = st_r.tick_cnt + 32'h0000_0001;
      end
      // Zero setting falls back to the fixed default
      bus_lim = (st_r.bus_tmo == 32'h0000_0000) ? bus_default_cyc
                                                : scale(st_r.bus_tmo, sel_tick_cyc);
      bus_lim_hit = st_r.bus_cnt >= bus_lim - 32'h0000_0001;
      st_nxt.bus_cnt = bus_lim_hit ? 32'h0000_0000 : st_r.bus_cnt + 32'h0000_0001;
      st_nxt.bus_timeout = bus_lim_hit;
      if (st_r.sel_tmo != 32'h0000_0000
          && st_r.sel_cnt >= scale(st_r.sel_tmo, sel_tick_cyc) - 32'h0000_0001) begin
        st_nxt.sel_cnt = 32'h0000_0000;
        st_nxt.sel_timeout = 1'b1;
      end else begin
        st_nxt.sel_cnt = st_r.sel_cnt + 32'h0000_0001;
      end
    end
    st_nxt.wq0_cnt = st_r.wq0_ticks;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign status_valid = st_r.status_valid;
  assign status_code = st_r.status_code;
  assign bus_timeout = st_r.bus_timeout;
  assign sel_timeout = st_r.sel_timeout;
endmodule // cmd_check

// >>> test/cmd_check_chk.sv
// Concurrent checks on the command checker ports
`timescale 1ns/10ps
module cmd_check_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic status_valid,
  input wire logic [7:0] status_code,
  input wire logic bus_timeout,
  input wire logic sel_timeout
);
  // ----------------------------------------
  // Shadow copies of the command info, list element and config registers and event bit 5
  // ----------------------------------------
  logic [31:0] ci_r;
  logic [31:0] sg_r;
  logic [31:0] cf_r;
  logic ev5_r;
  logic flushed_r;
  logic wr_w;
  logic chk_w;
  logic plain_w;
  logic sgsel_w;
  assign wr_w = psel & penable & pready & pwrite;
  assign chk_w = wr_w && paddr == cmd_check_pkg::REG_CONTROL && pwdata[0] && !flushed_r;
  assign plain_w = chk_w && !ci_r[19] && ci_r[7:0] <= cmd_check_pkg::TYPE_MAX;
  // Only pure list commands reach the element checks
  assign sgsel_w = plain_w && ci_r[18:16] == 3'b001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ci_r <= 32'h0;
      sg_r <= 32'h0;
      cf_r <= 32'h0;
      ev5_r <= 1'b0;
      flushed_r <= 1'b0;
    end else if (wr_w) begin
      if (paddr == cmd_check_pkg::REG_CMD_INFO) ci_r <= pwdata;
      if (paddr == cmd_check_pkg::REG_SG_ELEM) sg_r <= pwdata;
      if (paddr == cmd_check_pkg::REG_CONFIG) cf_r <= pwdata;
      if (paddr == cmd_check_pkg::REG_EVENT) ev5_r <= pwdata[5];
      // Flush modes are sticky here; the bench judges them instead
      if (paddr == cmd_check_pkg::REG_CONTROL && pwdata[1]) flushed_r <= 1'b1;
      if (paddr == cmd_check_pkg::REG_CONFIG && pwdata[2]) flushed_r <= 1'b1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_post(logic [7:0] c);
    ##1 status_valid && status_code == c;
  endsequence
  property p_rsvd;
    chk_w && ci_r[19] |-> s_post(8'h10);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code wrong");
  property p_type;
    chk_w && !ci_r[19] && ci_r[7:0] > 8'h03 |-> s_post(8'hC0);
  endproperty
  a_type: assert property (p_type) else $error("type code wrong");
  property p_prn_sg;
    plain_w && ci_r[17] && ci_r[16] |-> s_post(8'h99);
  endproperty
  a_prn_sg: assert property (p_prn_sg) else $error("printer list code wrong");
  property p_prn_absent;
    plain_w && ci_r[17:16] == 2'b10 && !cf_r[1] |-> s_post(8'h93);
  endproperty
  a_prn_absent: assert property (p_prn_absent) else $error("printer absent wrong");
  property p_buf_off;
    plain_w && ci_r[18:17] == 2'b10 && cf_r[0] |-> s_post(8'h51);
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("offboard code wrong");
  property p_sg_cnt;
    sgsel_w && (ci_r[15:8] == 8'h00 || ci_r[15:8] > 8'h40) |-> s_post(8'h2E);
  endproperty
  a_sg_cnt: assert property (p_sg_cnt) else $error("list count code wrong");
  property p_sg_odd;
    sgsel_w && ci_r[15:8] != 8'h00 && ci_r[15:8] <= 8'h40 && sg_r[0] |-> s_post(8'h40);
  endproperty
  a_sg_odd: assert property (p_sg_odd) else $error("odd count code wrong");
  property p_prn_change;
    wr_w && paddr == cmd_check_pkg::REG_EVENT && pwdata[5] && !ev5_r |-> ##1 s_post(8'h90);
  endproperty
  a_prn_change: assert property (p_prn_change) else $error("printer change wrong");
  property p_single;
    status_valid |=> !status_valid;
  endproperty
  a_single: assert property (p_single) else $error("status posted twice");
endmodule // cmd_check_chk

bind cmd_check cmd_check_chk chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .status_valid(status_valid), .status_code(status_code), .bus_timeout(bus_timeout),
  .sel_timeout(sel_timeout)
);

// >>> test/apb_host.sv
// Host processor model issuing register transfers
`timescale 1ns/10ps
module apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int hangs = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Entered just after a rising edge; one idle cycle follows each transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hangs++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Scramble released write data so stale values are never trusted
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule // apb_host

// >>> test/test_cmd_check.sv
// Self-checking bench for the command checker
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); \
  end \
end
module test_cmd_check;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic status_valid;
  logic [7:0] status_code;
  logic bus_timeout;
  logic sel_timeout;
  int errors = 0;
  int check_count = 0;
  int n;
  logic [7:0] exp_q[$];
  logic [7:0] e_m;
  logic [31:0] rd_v;
  logic err_v;
  logic [15:0] cnt_v;
  logic [3:0] mt_v;
  logic [31:0] el_v;
  cmd_check dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .status_valid, .status_code, .bus_timeout, .sel_timeout);
  apb_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  initial pclk = 1'b0;
  initial presetn = 1'b0;
  always #2 pclk = ~pclk;
  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge pclk) begin
    if (status_valid === 1'b1) begin
      e_m = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hEE;
      `CHK("status_code", e_m, status_code)
    end
    // Timeout periods are far beyond this run, so no pulse may appear
    if (presetn === 1'b1 && (bus_timeout !== 1'b0 || sel_timeout !== 1'b0)) begin
      `CHK("timeout pulse", 2'b00, {bus_timeout, sel_timeout})
    end
  end
  task automatic end_sim();
    errors += host.hangs;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd_v, err_v);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, rd_v, err_v);
  endtask
  task automatic run(input logic [31:0] ci, input logic [31:0] sg, input logic [31:0] ln,
                     input logic [31:0] cf, input logic [7:0] code);
    wr(cmd_check_pkg::REG_CMD_INFO, ci);
    wr(cmd_check_pkg::REG_SG_ELEM, sg);
    wr(cmd_check_pkg::REG_LENGTHS, ln);
    wr(cmd_check_pkg::REG_CONFIG, cf);
    exp_q.push_back(code);
    wr(cmd_check_pkg::REG_CONTROL, 32'h1);
  endtask
  // Link events other than printer change count only while running, so each one starts and ends a run
  task automatic ev(input logic [31:0] d, input logic [7:0] code);
    wr(cmd_check_pkg::REG_CONTROL, 32'h8);
    exp_q.push_back(code);
    wr(cmd_check_pkg::REG_EVENT, d);
    wr(cmd_check_pkg::REG_EVENT, 32'h0);
    wr(cmd_check_pkg::REG_CONTROL, 32'h10);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_sim();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(51522));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    run(32'h000F_00FF, 32'h1, 32'h0, 32'h0, 8'h10);
    for (n = 0; n < 4; n++) begin
      run(32'(4 + $urandom % 252), 32'h0, 32'h0, 32'h0, 8'hC0);
    end
    run(32'h3, 32'h0, 32'h0, 32'h0, 8'h00);
    $display("test decode done");
    run(32'h0003_0000, 32'h0, 32'h0, 32'h0, 8'h99);
    run(32'h0002_0000, 32'h0, 32'h0010_0010, 32'h0, 8'h93);
    run(32'h0002_0000, 32'h0, 32'h0010_0000, 32'h2, 8'h92);
    run(32'h0002_0000, 32'h0, 32'h0010_000F, 32'h2, 8'h91);
    run(32'h0002_0000, 32'h0, 32'h0010_0010, 32'h2, 8'h00);
    $display("test printer done");
    run(32'h0004_0000, 32'h0, 32'h0000_0200, 32'h0100_0001, 8'h51);
    run(32'h0004_0000, 32'h0, 32'h0000_0101, 32'h0100_0000, 8'h50);
    run(32'h0004_0000, 32'h0, 32'h0000_0100, 32'h0100_0000, 8'h00);
    $display("test buffer done");
    cnt_v = 16'($urandom) & 16'hFFFE;
    mt_v = 4'($urandom % 4);
    el_v = {11'h0, 1'b1, mt_v, cnt_v};
    run(32'h0001_0000, el_v, 32'h0, 32'h0, 8'h2E);
    run(32'h0001_4100, el_v, 32'h0, 32'h0, 8'h2E);
    run(32'h0001_4000, el_v, 32'h0, 32'h0, 8'h00);
    run(32'h0001_0100, el_v | 32'h1, 32'h0, 32'h0, 8'h40);
    el_v[19:16] = 4'(4 + $urandom % 12);
    run(32'h0001_0100, el_v, 32'h0, 32'h0, 8'h41);
    run(32'h0001_0100, el_v | 32'h1, 32'h0, 32'h0, 8'h40);
    run(32'h0001_0100, {11'h0, 1'b0, mt_v, cnt_v}, 32'h0, 32'h0, 8'h42);
    $display("test list done");
    wr(cmd_check_pkg::REG_CMD_INFO, 32'h0);
    ev(32'h1, 8'h82);
    ev(32'hC, 8'h83);
    wr(cmd_check_pkg::REG_CMD_INFO, 32'h0010_0000);
    ev(32'h8, 8'h84);
    exp_q.push_back(8'h90);
    wr(cmd_check_pkg::REG_EVENT, 32'h20);
    wr(cmd_check_pkg::REG_EVENT, 32'h0);
    rd(cmd_check_pkg::REG_STATUS);
    `CHK("status reg", 8'h90, rd_v[7:0])
    $display("test events done");
    rd(8'h3C);
    `CHK("pslverr", 1'b1, err_v)
    for (n = 0; n < 2; n++) begin
      cnt_v = 16'($urandom);
      wr(n ? cmd_check_pkg::REG_SEL_TMO : cmd_check_pkg::REG_WQ0_TMO, {16'h0, cnt_v});
      rd(n ? cmd_check_pkg::REG_SEL_TMO : cmd_check_pkg::REG_WQ0_TMO);
      `CHK("timeout reg", cnt_v, rd_v[15:0])
    end
    $display("test registers done");
    run(32'hFF, 32'h0, 32'h0, 32'h4, 8'hC0);
    run(32'h0, 32'h0, 32'h0, 32'h4, 8'h80);
    run(32'h0, 32'h0, 32'h0, 32'h4, 8'h80);
    wr(cmd_check_pkg::REG_CONTROL, 32'h4);
    run(32'h0, 32'h0, 32'h0, 32'h0, 8'h00);
    wr(cmd_check_pkg::REG_CONTROL, 32'h2);
    exp_q.push_back(8'h81);
    wr(cmd_check_pkg::REG_CONTROL, 32'h3);
    $display("test flush done");
    n = 0;
    while (exp_q.size() != 0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (exp_q.size() != 0) errors++;
    end_sim();
  end
endmodule // test_cmd_check
